/* File: asc_cal_bank.sv */
`timescale 1ns/1ps
`include "asc_regs.svh"

module asc_cal_bank #(
  parameter int CAL_N = `CAL_COUNT
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  restart,
  input  wire asc_pkg::asc_cal_sel_t cal_sel,
  input  wire logic                  advance,
  input  wire logic                  host_wr,
  input  wire logic [15:0]           host_data,
  input  wire logic                  eng_wr,
  input  wire logic [3:0]            eng_idx,
  input  wire logic [13:0]           eng_data,
  output logic      [15:0]           rd_data
);
  import asc_pkg::*;

  if (CAL_N != `CAL_COUNT) begin : g_bad_n
    $error("asc_cal_bank serves exactly ten calibration entries");
  end

  logic [13:0] cal_mem [CAL_N];
  logic [3:0]  ptr_reg;
  logic [3:0]  ptr_next;
  logic [3:0]  first_idx;
  logic [3:0]  last_idx;

  // RULE15 select code bounds.
  assign first_idx = asc_cal_first(cal_sel);
  assign last_idx  = asc_cal_last(cal_sel);

  // RULE19 restart position, RULE20 auto step, RULE25 ascending order.
  // RULE18 wrap at sequence end.
  assign ptr_next = restart ? first_idx :
                    !advance ? ptr_reg :
                    (ptr_reg == last_idx) ? first_idx : ptr_reg + 4'h1;

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_reg <= `CAL_IDX_GAIN;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // The calibration engine wins a same-cycle collision with a host write,
  // since its result is the fresher coefficient.
  for (genvar i = 0; i < CAL_N; i++) begin : g_ent
    // RULE13 host access, RULE14 engine update.
    always_ff @(posedge clk) begin
      if (rst) begin
        cal_mem[i] <= `CAL_RST;
      end else if (eng_wr && eng_idx == 4'(i)) begin
        cal_mem[i] <= eng_data;
      end else if (host_wr && ptr_reg == 4'(i)) begin
        cal_mem[i] <= host_data[13:0];
      end
    end
  end

  // RULE23 leading zeros, RULE24 fourteen data bits.
  assign rd_data = {2'h0, cal_mem[ptr_reg]};

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_ptr_restart: assert property (restart |=> ptr_reg == $past(first_idx)) // RULE19
    else $error("pointer did not return to sequence start");
  chk_ptr_step: assert property ( // RULE20
    advance && !restart && ptr_reg != last_idx |=> ptr_reg == $past(ptr_reg) + 4'h1)
    else $error("pointer did not step after access");
  chk_ptr_wrap: assert property ( // RULE18
    advance && !restart && ptr_reg == last_idx |=> ptr_reg == $past(first_idx))
    else $error("pointer did not reset at sequence end");
  chk_host_store: assert property ( // RULE13
    host_wr && !(eng_wr && eng_idx == ptr_reg)
      |=> cal_mem[$past(ptr_reg)] == $past(host_data[13:0]))
    else $error("host write not stored");
endmodule

/* File: asc_host_model.sv */
`timescale 1ns/1ps

// ****************************************************************
// Host processor on the parallel port
// ****************************************************************
module asc_host_model (
  input  wire logic        clk,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe_n,
  output logic             cs_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             hbs,
  output logic             reg_target,
  output logic             byte_mode,
  output logic      [15:0] data_in
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    hbs = 1'b0;
    reg_target = 1'b0;
    byte_mode = 1'b0;
    data_in = 16'h0000;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task automatic set_mode(input logic m);
    step(1);
    byte_mode = m;
  endtask

  // Strobes stay low three clocks and high five, above the two-clock minimum.
  // whole accesses
  task automatic bus_write(input logic tgt, input logic hb, input logic [15:0] d);
    step(1);
    reg_target = tgt;
    hbs = hb;
    data_in = d;
    cs_n = 1'b0;
    wr_n = 1'b0;
    step(3);
    cs_n = 1'b1;
    wr_n = 1'b1;
    step(5);
    data_in = ~d;
  endtask

  // Data is taken just after the edge at which the output enable has gone low,
  // so that it is never sampled in the time step that launches it.
  task automatic bus_read(input logic hb, output logic [15:0] d);
    int n;
    n = 0;
    step(1);
    hbs = hb;
    cs_n = 1'b0;
    rd_n = 1'b0;
    do begin
      step(1);
      n++;
    end while (data_oe_n !== 1'b0 && n < 10);
    // A read that the port never answered must not pass on stale data.
    d = (data_oe_n === 1'b0) ? data_out : 16'hxxxx;
    cs_n = 1'b1;
    rd_n = 1'b1;
    step(5);
  endtask
endmodule

/* File: asc_pkg.sv */
`include "asc_regs.svh"

package asc_pkg;

  typedef enum logic [1:0] {
    RDS_RESULT_A = 2'h0,
    RDS_RESULT_B = 2'h1,
    RDS_CAL      = 2'h2,
    RDS_STATUS   = 2'h3
  } asc_rd_sel_t;

  typedef enum logic [1:0] {
    CSEL_ALL      = 2'h0,
    CSEL_GAIN_OFS = 2'h1,
    CSEL_OFS      = 2'h2,
    CSEL_GAIN     = 2'h3
  } asc_cal_sel_t;

  typedef enum logic [2:0] {
    PS_IDLE  = 3'h1,
    PS_READ  = 3'h2,
    PS_WRITE = 3'h4
  } asc_port_st_t;

  function automatic logic [3:0] asc_cal_first(asc_cal_sel_t s);
    return (s == CSEL_OFS) ? `CAL_IDX_OFFSET : `CAL_IDX_GAIN;
  endfunction

  function automatic logic [3:0] asc_cal_last(asc_cal_sel_t s);
    logic [3:0] r;
    r = `CAL_IDX_GAIN;
    unique case (s)
      CSEL_ALL:      r = `CAL_IDX_LAST;
      CSEL_GAIN_OFS: r = `CAL_IDX_OFFSET;
      CSEL_OFS:      r = `CAL_IDX_OFFSET;
      CSEL_GAIN:     r = `CAL_IDX_GAIN;
    endcase
    return r;
  endfunction

endpackage

/* File: asc_regs.svh */
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

// ****************************************************************
// Control word field positions (LSB of each field)
// ****************************************************************
`define CTL_RDSEL_LSB   0
`define CTL_CALSEL_LSB  2
`define CTL_CALKIND_BIT 4
`define CTL_CALIBRATION_RUNNING_BIT   5
`define CTL_ANALOG_INPUT_MODE_BIT   6
`define CTL_PWR_LSB     7
`define CTL_CHSEL_LSB   9
`define CTL_SGL_BIT     12
`define CTL_RST         16'h0000
`define CTL_WMASK       16'h1fdf

// ****************************************************************
// Status word fixed fields
// ****************************************************************
`define STAT_ZERO_HI    2'h0
`define STAT_ONE_MID    2'h3

// ****************************************************************
// Calibration bank layout
// ****************************************************************
`define CAL_COUNT       10
`define CAL_DATA_W      14
`define CAL_IDX_GAIN    4'h0
`define CAL_IDX_OFFSET  4'h1
`define CAL_IDX_LAST    4'h9
`define CAL_RST         14'h0000

// ****************************************************************
// Pin synchroniser reset value: strobes idle high
// ****************************************************************
`define SYNC_RST        22'h380000

`endif

/* File: asc_status_cal.sv */
`timescale 1ns/1ps
`include "asc_regs.svh"

// Function
// RULE1 - Sixteen-bit status word is read only; no write changes it.
// RULE2 - Host selects status by writing both read-select bits as ones.
// RULE3 - At power-up every variable status bit is cleared.
// RULE4 - Status bits 15 and 14 always read zero.
// RULE5 - Status bits 7 and 6 always read one.
// RULE6 - Bits 13 to 10 report input mode and channel selection.
// RULE7 - Bits 9 and 8 report the two power setting bits.
// RULE8 - Bit 5 reports the analog input mode setting.
// RULE9 - Bit 4 is one while conversion or calibration runs.
// RULE10 - Bit 3 reports calibration kind: self or system.
// RULE11 - Bits 2 and 1 report the calibration select bits.
// RULE12 - Bit 0 is one while a calibration runs.
// RULE13 - Ten calibration registers, all host readable and writable.
// RULE14 - Calibration updates the registers automatically.
// RULE15 - Select code chooses ten, gain-offset, offset, or gain registers.
// RULE16 - Same addressing for reads and writes; host never mixes them.
// RULE17 - Host sets read-select to binary 10 before calibration reads.
// RULE18 - Pointer resets on control write and at sequence end.
// RULE19 - Pointer starts at gain, or offset when offset alone selected.
// RULE20 - Pointer advances after each complete register access.
// RULE21 - In byte mode the high byte completes access; low byte first.
// RULE22 - Abandoned sequences end at the next control write.
// RULE23 - Calibration reads return two leading zeros.
// RULE24 - Offset and gain registers hold fourteen data bits below zeros.
// RULE25 - Ten-register sequence runs gain, offset, then DAC ascending.
module asc_status_cal #(
  parameter int DATA_W = 16
) (
  input  wire logic                  CORE_CLK,
  input  wire logic                  RST,
  input  wire logic                  CS_N,
  input  wire logic                  RD_N,
  input  wire logic                  WR_N,
  input  wire logic                  HIGH_BYTE_SELECT,
  input  wire logic                  REG_TARGET,
  input  wire logic                  BYTE_MODE,
  input  wire logic [15:0]           DATA_IN,
  output logic      [15:0]           DATA_OUT,
  output logic                       DATA_OE_N,
  input  wire logic                  CONV_BUSY,
  input  wire logic [11:0]           CONV_RESULT,
  input  wire logic                  CAL_DONE,
  input  wire logic                  CAL_ENG_WR,
  input  wire logic [3:0]            CAL_ENG_IDX,
  input  wire logic [13:0]           CAL_ENG_DATA,
  output logic                       SINGLE_OR_DIFFERENTIAL,
  output logic      [2:0]            CHANNEL_SELECT,
  output logic      [1:0]            POWER_SETTING,
  output logic                       ANALOG_INPUT_MODE,
  output logic                       CALIBRATION_KIND,
  output asc_pkg::asc_cal_sel_t      CAL_SELECT,
  output logic                       CALIBRATION_RUNNING,
  output logic                       CAL_START
);
  import asc_pkg::*;

  if (DATA_W != 16) begin : g_bad_w
    $error("asc_status_cal supports a 16-bit host port only");
  end

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  // Every host pin crosses two flops. Data is resampled on each cycle
  // of the write strobe, so the last stable value before release is kept.
  logic [21:0] meta_reg;
  logic [21:0] sync_reg;
  logic [21:0] pins_raw;

  assign pins_raw = {CS_N, RD_N, WR_N, HIGH_BYTE_SELECT, REG_TARGET, BYTE_MODE, DATA_IN};

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      meta_reg <= `SYNC_RST;
      sync_reg <= `SYNC_RST;
    end else begin
      meta_reg <= pins_raw;
      sync_reg <= meta_reg;
    end
  end

  logic        cs_n_s;
  logic        rd_n_s;
  logic        wr_n_s;
  logic        high_byte_select_s;
  logic        tgt_s;
  logic        byte_s;
  logic [15:0] data_s;

  assign {cs_n_s, rd_n_s, wr_n_s, high_byte_select_s, tgt_s, byte_s, data_s} = sync_reg;

  // ****************************************************************
  // Host port sequencer
  // ****************************************************************
  asc_port_st_t st_reg;
  asc_port_st_t st_next;
  logic         rd_act;
  logic         wr_act;
  logic         rd_start;
  logic         rd_done;
  logic         wr_start;
  logic         wr_done;

  assign rd_act   = !cs_n_s && !rd_n_s;
  assign wr_act   = !cs_n_s && !wr_n_s;
  assign rd_start = (st_reg == PS_IDLE) && rd_act;
  assign wr_start = (st_reg == PS_IDLE) && !rd_act && wr_act;
  assign rd_done  = (st_reg == PS_READ) && !rd_act;
  assign wr_done  = (st_reg == PS_WRITE) && !wr_act;

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      PS_IDLE: begin
        if (rd_act) begin
          st_next = PS_READ;
        end else if (wr_act) begin
          st_next = PS_WRITE;
        end
      end
      PS_READ: begin
        if (!rd_act) begin
          st_next = PS_IDLE;
        end
      end
      PS_WRITE: begin
        if (!wr_act) begin
          st_next = PS_IDLE;
        end
      end
      default: st_next = PS_IDLE;
    endcase
  end

  // Access attributes are frozen at the strobe's leading edge so that a
  // byte-select change mid-strobe cannot split one access into two.
  logic        acc_hi_reg;
  logic        acc_byte_reg;
  logic        acc_tgt_reg;
  logic [15:0] wr_data_reg;
  logic [7:0]  lo_byte_reg;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_reg       <= PS_IDLE;
      acc_hi_reg   <= 1'b0;
      acc_byte_reg <= 1'b0;
      acc_tgt_reg  <= 1'b0;
      wr_data_reg  <= 16'h0000;
    end else begin
      st_reg <= st_next;
      if (rd_start || wr_start) begin
        acc_hi_reg   <= high_byte_select_s;
        acc_byte_reg <= byte_s;
        acc_tgt_reg  <= tgt_s;
      end
      if (wr_act) begin
        wr_data_reg <= data_s;
      end
    end
  end

  // RULE21 high byte completes the access.
  logic        acc_full;
  logic        ctl_wr;
  logic        cal_wr;
  logic        lo_wr;
  logic [15:0] wr_word;

  assign acc_full = !acc_byte_reg || acc_hi_reg;
  assign lo_wr    = wr_done && acc_byte_reg && !acc_hi_reg;
  assign ctl_wr   = wr_done && acc_full && !acc_tgt_reg;
  assign cal_wr   = wr_done && acc_full && acc_tgt_reg;
  assign wr_word  = acc_byte_reg ? {wr_data_reg[7:0], lo_byte_reg} : wr_data_reg;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      lo_byte_reg <= 8'h00;
    end else if (lo_wr) begin
      lo_byte_reg <= wr_data_reg[7:0];
    end
  end

  // ****************************************************************
  // Control word and calibration activity
  // ****************************************************************
  logic [15:0]  ctrl_reg;
  logic         cal_run_reg;
  logic         cal_run_next;
  logic         cal_start_reg;
  logic         cal_go;
  asc_rd_sel_t  rd_sel;
  asc_cal_sel_t cal_sel;

  assign rd_sel  = asc_rd_sel_t'(ctrl_reg[`CTL_RDSEL_LSB +: 2]);
  assign cal_sel = asc_cal_sel_t'(ctrl_reg[`CTL_CALSEL_LSB +: 2]);
  assign cal_go  = ctl_wr && wr_word[`CTL_CALIBRATION_RUNNING_BIT];

  // RULE12 start wins over a same-cycle done.
  assign cal_run_next = cal_go || (cal_run_reg && !CAL_DONE);

  // RULE3 power-up clear.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ctrl_reg      <= `CTL_RST;
      cal_run_reg   <= 1'b0;
      cal_start_reg <= 1'b0;
    end else begin
      if (ctl_wr) begin
        ctrl_reg <= wr_word & `CTL_WMASK;
      end
      cal_run_reg   <= cal_run_next;
      cal_start_reg <= cal_go;
    end
  end

  assign SINGLE_OR_DIFFERENTIAL = ctrl_reg[`CTL_SGL_BIT];
  assign CHANNEL_SELECT         = ctrl_reg[`CTL_CHSEL_LSB +: 3];
  assign POWER_SETTING          = ctrl_reg[`CTL_PWR_LSB +: 2];
  assign ANALOG_INPUT_MODE      = ctrl_reg[`CTL_ANALOG_INPUT_MODE_BIT];
  assign CALIBRATION_KIND       = ctrl_reg[`CTL_CALKIND_BIT];
  assign CAL_SELECT             = cal_sel;
  assign CALIBRATION_RUNNING    = cal_run_reg;
  assign CAL_START              = cal_start_reg;

  // ****************************************************************
  // Status word and calibration bank
  // ****************************************************************
  // RULE1 built from state and CONV_BUSY, never written.
  // RULE4 zeros, RULE5 ones, RULE6 RULE7 RULE8 RULE9 RULE10 RULE11 mirror.
  logic [15:0] status_word;
  logic        busy;

  assign busy        = CONV_BUSY || cal_run_reg;
  assign status_word = {`STAT_ZERO_HI, ctrl_reg[`CTL_SGL_BIT], ctrl_reg[`CTL_CHSEL_LSB +: 3],
                        ctrl_reg[`CTL_PWR_LSB +: 2], `STAT_ONE_MID,
                        ctrl_reg[`CTL_ANALOG_INPUT_MODE_BIT], busy, ctrl_reg[`CTL_CALKIND_BIT],
                        ctrl_reg[`CTL_CALSEL_LSB +: 2], cal_run_reg};

  // RULE17 read-select 10 routes reads into the bank.
  logic        cal_rd;
  logic        cal_adv;
  logic [15:0] cal_rd_data;

  assign cal_rd  = rd_done && acc_full && (rd_sel == RDS_CAL);
  // RULE16 shared pointer for reads and writes.
  assign cal_adv = cal_rd || cal_wr;

  // RULE18 RULE22 every control write restarts the pointer.
  asc_cal_bank #(
    .CAL_N(`CAL_COUNT)
  ) u_bank (
    .clk      (CORE_CLK),
    .rst      (RST),
    .restart  (ctl_wr),
    .cal_sel  (asc_cal_sel_t'(ctl_wr ? wr_word[`CTL_CALSEL_LSB +: 2]
                                     : ctrl_reg[`CTL_CALSEL_LSB +: 2])),
    .advance  (cal_adv),
    .host_wr  (cal_wr),
    .host_data(wr_word),
    .eng_wr   (CAL_ENG_WR),
    .eng_idx  (CAL_ENG_IDX),
    .eng_data (CAL_ENG_DATA),
    .rd_data  (cal_rd_data)
  );

  // ****************************************************************
  // Read data path
  // ****************************************************************
  // RULE2 read-select 11 returns the status word.
  logic [15:0] rd_word;
  logic [15:0] rd_lane;
  logic        oe_n_next;
  logic [15:0] dout_reg;
  logic        oe_n_reg;

  assign rd_word   = (rd_sel == RDS_STATUS) ? status_word :
                     (rd_sel == RDS_CAL)    ? cal_rd_data : {4'h0, CONV_RESULT};
  assign rd_lane   = !byte_s ? rd_word :
                     high_byte_select_s  ? {8'h00, rd_word[15:8]} : {8'h00, rd_word[7:0]};
  assign oe_n_next = !(rd_start || ((st_reg == PS_READ) && rd_act));

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      dout_reg <= 16'h0000;
      oe_n_reg <= 1'b1;
    end else begin
      if (rd_start) begin
        dout_reg <= rd_lane;
      end
      oe_n_reg <= oe_n_next;
    end
  end

  assign DATA_OUT  = dout_reg;
  assign DATA_OE_N = oe_n_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence s_status_word_read;
    rd_start && !byte_s && rd_sel == RDS_STATUS;
  endsequence

  sequence s_cal_launch;
    cal_go ##1 (cal_run_reg && CAL_START);
  endsequence

  chk_status_zero_top: assert property ( // RULE4
    s_status_word_read |=> DATA_OUT[15:14] == 2'h0)
    else $error("status top bits not zero");
  chk_status_one_mid: assert property ( // RULE5
    s_status_word_read |=> DATA_OUT[7:6] == 2'h3)
    else $error("status marker bits not one");
  chk_status_chan: assert property ( // RULE6
    s_status_word_read |=> DATA_OUT[13:10] == $past(ctrl_reg[12:9]))
    else $error("status channel field mismatch");
  chk_status_busy: assert property ( // RULE9
    s_status_word_read |=> DATA_OUT[4] == $past(busy))
    else $error("status busy bit mismatch");
  chk_status_ro: assert property ( // RULE1
    cal_wr || lo_wr |=> $stable(ctrl_reg))
    else $error("state changed by non-control write");
  chk_cal_launch: assert property ( // RULE12
    cal_go |-> s_cal_launch ##1 !CAL_START)
    else $error("calibration start not flagged for one cycle");
  chk_cal_hold: assert property ( // RULE12
    cal_run_reg && !CAL_DONE && !cal_go |=> cal_run_reg)
    else $error("calibration flag dropped early");
  chk_cal_lead_zero: assert property ( // RULE23
    rd_start && !byte_s && rd_sel == RDS_CAL |=> DATA_OUT[15:14] == 2'h0)
    else $error("calibration read lacks leading zeros");
  chk_byte_no_adv: assert property ( // RULE21
    lo_wr |-> !cal_adv)
    else $error("low byte advanced the pointer");
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps

module tb_top;
  import asc_pkg::*;

  logic                 clk;
  logic                 rst;
  logic                 cs_n;
  logic                 rd_n;
  logic                 wr_n;
  logic                 hbs;
  logic                 tgt;
  logic                 bmode;
  logic          [15:0] din;
  logic          [15:0] dout;
  logic                 oe_n;
  logic                 busy;
  logic                 done;
  logic                 ewr;
  logic          [3:0]  eidx;
  logic          [13:0] edat;
  logic          [11:0] res;
  logic                 sgl;
  logic          [2:0]  chan;
  logic          [1:0]  pwr;
  logic                 analog_input_mode;
  logic                 kind;
  asc_cal_sel_t         csel;
  logic                 running;
  logic                 start;
  logic          [15:0] rd;
  int                   failures = 0;
  int                   check_count = 0;
  int                   starts = 0;
  logic          [15:0] row_ctl  [4] = '{16'h0003, 16'h1b57, 16'he48b, 16'hffdf};
  logic          [15:0] row_stat [4] = '{16'h00c0, 16'h36ea, 16'h09c4, 16'h3fee};
  logic          [7:0]  bexp     [4] = '{8'h21, 8'h3c, 8'h43, 8'h15};

  asc_host_model host_u (
    .clk        (clk),
    .data_out   (dout),
    .data_oe_n  (oe_n),
    .cs_n       (cs_n),
    .rd_n       (rd_n),
    .wr_n       (wr_n),
    .hbs        (hbs),
    .reg_target (tgt),
    .byte_mode  (bmode),
    .data_in    (din)
  );

  asc_status_cal dut_u (
    .CORE_CLK               (clk),
    .RST                    (rst),
    .CS_N                   (cs_n),
    .RD_N                   (rd_n),
    .WR_N                   (wr_n),
    .HIGH_BYTE_SELECT       (hbs),
    .REG_TARGET             (tgt),
    .BYTE_MODE              (bmode),
    .DATA_IN                (din),
    .DATA_OUT               (dout),
    .DATA_OE_N              (oe_n),
    .CONV_BUSY              (busy),
    .CONV_RESULT            (res),
    .CAL_DONE               (done),
    .CAL_ENG_WR             (ewr),
    .CAL_ENG_IDX            (eidx),
    .CAL_ENG_DATA           (edat),
    .SINGLE_OR_DIFFERENTIAL (sgl),
    .CHANNEL_SELECT         (chan),
    .POWER_SETTING          (pwr),
    .ANALOG_INPUT_MODE      (analog_input_mode),
    .CALIBRATION_KIND       (kind),
    .CAL_SELECT             (csel),
    .CALIBRATION_RUNNING    (running),
    .CAL_START              (start)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (start === 1'b1) begin
      starts <= starts + 1;
    end
  end

  // ****************************************************************
  // Checking and verdict
  // ****************************************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Coefficient pattern with a distinct value in each entry.
  function automatic logic [15:0] expv(input int k);
    return 16'h0a50 + 16'(k) * 16'h0111;
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    busy = 1'b0;
    done = 1'b0;
    ewr = 1'b0;
    eidx = 4'h0;
    edat = 14'h0000;
    res = 12'h000;
    repeat (4) @(posedge clk);
    #10;
    rst = 1'b0;
    check("oe_n", {15'h0, oe_n}, 16'h0001);
    check("dout", dout, 16'h0000);
    check("running", {15'h0, running}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      host_u.bus_write(1'b0, 1'b0, row_ctl[i]);
      check("fields", {3'h0, sgl, chan, pwr, analog_input_mode, 1'b0, kind, csel, 2'h3},
            row_ctl[i] & 16'h1fdf);
      host_u.bus_read(1'b0, rd);
      check("status", rd, row_stat[i]);
    end
    host_u.bus_write(1'b1, 1'b0, 16'hffff);
    host_u.bus_read(1'b0, rd);
    check("status_wr", rd, 16'h3fee);
    check("oe_n_idle", {15'h0, oe_n}, 16'h0001);
    busy = 1'b1;
    host_u.bus_read(1'b0, rd);
    check("status_busy", rd, 16'h3ffe);
    busy = 1'b0;
    host_u.bus_write(1'b0, 1'b0, 16'hffff);
    check("starts", 16'(starts), 16'h0001);
    host_u.bus_read(1'b0, rd);
    check("status_cal", rd, 16'h3fff);
    host_u.step(1);
    done = 1'b1;
    host_u.step(1);
    done = 1'b0;
    host_u.bus_read(1'b0, rd);
    check("status_done", rd, 16'h3fee);
    // Read-select codes 00 and 01 both return the conversion result.
    for (int r = 0; r < 2; r++) begin
      host_u.bus_write(1'b0, 1'b0, 16'(r));
      res = 12'h5a3 ^ {12{r[0]}};
      host_u.bus_read(1'b0, rd);
      check("result", rd, {4'h0, 12'h5a3 ^ {12{r[0]}}});
    end
    for (int k = 0; k < 10; k++) begin
      host_u.bus_write(1'b1, 1'b0, expv(k) | 16'hc000);
    end
    host_u.bus_write(1'b0, 1'b0, 16'h0002);
    for (int k = 0; k < 11; k++) begin
      host_u.bus_read(1'b0, rd);
      check("cal_all", rd, expv(k % 10));
    end
    for (int s = 0; s < 4; s++) begin
      host_u.bus_write(1'b0, 1'b0, 16'h0002 | 16'(s << 2));
      for (int j = 0; j < 3; j++) begin
        host_u.bus_read(1'b0, rd);
        check("cal_sel", rd, expv((s == 0) ? j : (s == 1) ? j % 2 : (s == 2) ? 1 : 0));
      end
    end
    host_u.set_mode(1'b1);
    host_u.bus_write(1'b0, 1'b0, 16'ha504);
    host_u.bus_write(1'b0, 1'b1, 16'ha500);
    host_u.bus_write(1'b1, 1'b0, 16'h5a21);
    host_u.bus_write(1'b1, 1'b1, 16'h5afc);
    host_u.bus_write(1'b1, 1'b0, 16'h5a43);
    host_u.bus_write(1'b1, 1'b1, 16'h5a15);
    host_u.bus_write(1'b0, 1'b0, 16'ha506);
    host_u.bus_write(1'b0, 1'b1, 16'ha500);
    for (int j = 0; j < 4; j++) begin
      host_u.bus_read(j[0], rd);
      check("cal_byte", rd, {8'h00, bexp[j]});
    end
    host_u.set_mode(1'b0);
    // engine writes gain, then offset, each read back alone.
    for (int k = 0; k < 2; k++) begin
      host_u.step(1);
      eidx = 4'(k);
      edat = 14'h2bcd + 14'(k);
      ewr = 1'b1;
      host_u.step(1);
      ewr = 1'b0;
      host_u.bus_write(1'b0, 1'b0, (k == 0) ? 16'h000e : 16'h000a);
      host_u.bus_read(1'b0, rd);
      check("cal_engine", rd, 16'h2bcd + 16'(k));
    end
    // reset in mid-run, with a calibration running and data on the port.
    host_u.bus_write(1'b0, 1'b0, 16'h1fff);
    host_u.bus_read(1'b0, rd);
    check("status_run", rd, 16'h3fff);
    rst = 1'b1;
    host_u.step(4);
    rst = 1'b0;
    check("rst_fields", {3'h0, sgl, chan, pwr, analog_input_mode, running, kind, csel, 2'h0},
          16'h0000);
    check("rst_port", {dout[15:1], oe_n}, 16'h0001);
    host_u.bus_write(1'b0, 1'b0, 16'h0003);
    host_u.bus_read(1'b0, rd);
    check("rst_status", rd, 16'h00c0);
    give_verdict();
  end
endmodule
